// *** verilog/mbac_cfg.svh ***
/*
 Constants of the access checker: offsets, reset values, regions, register groups.
 Assumes 16-bit memory addresses and 8-bit special-register addresses.
*/
// What this block does
// - boot mode: test ROM rx, OS EEPROM rwx, OS RAM rw.
// - test mode: whole ROM rx, whole EEPROM rwx, whole RAM rw.
// - contactless OS mode has boot mode memory rights.
// - system mode: application ROM rx, EEPROM rwx, RAM rw.
// - user mode memory rights come from the matching segment entry.
// - contactless OS mode reads the 64-byte access matrix in ROM.
// - contactless OS mode uses the RAM exchange window.
// - boot and contactless OS modes read EEPROM security rows.
// - coprocessor reads EEPROM and reads/writes its own RAM.
// - boot and test modes reach every register group except segmentation.
// - contactless OS: firewall regs read, own regs rw, hardware regs per firewall.
// - system mode reaches segmentation, system, firewall and hardware groups.
// - user mode hardware rights come from the current code segment.
// - general CPU registers are open in every mode.
// - program status high readable in contactless OS and user modes.
// - clock source select always readable in contactless OS mode.
// - segmentation registers refused outside system mode.
// - hidden system registers never return contents.
// - random number register writes never take effect.
// - key registers never return contents.
// - refused reads return zero, refused writes change nothing.
// - up to 64 segments; an entry granting nothing is disabled.
// - five modes from program status high and two internal bits.
`ifndef MBAC_CFG_SVH
`define MBAC_CFG_SVH

// Register offsets (byte addresses)
`define MBAC_OFF_MODE 12'h000
`define MBAC_OFF_FWLO 12'h004
`define MBAC_OFF_FWHI 12'h008
`define MBAC_OFF_XBLO 12'h00C
`define MBAC_OFF_XBHI 12'h010
`define MBAC_OFF_XSLO 12'h014
`define MBAC_OFF_XSHI 12'h018
`define MBAC_OFF_STAT 12'h01C
`define MBAC_OFF_SEG 12'h100
`define MBAC_SEG_COUNT 64

// Reset values: restrictive, user mode, all segments disabled
`define MBAC_RST_MODE 3'h0
`define MBAC_RST_BYTE 8'h00
`define MBAC_RST_SEG 24'h000000

// Segment entry fields
`define MBAC_SEG_R 0
`define MBAC_SEG_W 1
`define MBAC_SEG_X 2
`define MBAC_SEG_HWR 3
`define MBAC_SEG_HWW 4
`define MBAC_SEG_FIRST 15:8
`define MBAC_SEG_LAST 23:16

// Memory regions (inclusive bounds)
`define MBAC_TROM_LO 16'h0000
`define MBAC_TROM_HI 16'h0FFF
`define MBAC_ACM_LO 16'h1000
`define MBAC_ACM_HI 16'h103F
`define MBAC_CLEE_LO 16'h0000
`define MBAC_CLEE_HI 16'h0FFF
`define MBAC_SECROW_LO 16'h1000
`define MBAC_SECROW_HI 16'h107F
`define MBAC_CLRAM_LO 16'h0000
`define MBAC_CLRAM_HI 16'h00FF

// Special-register groups
`define MBAC_SFR_SEG_LO 8'h80
`define MBAC_SFR_SEG_HI 8'h87
`define MBAC_SFR_SYS_LO 8'h88
`define MBAC_SFR_SYS_HI 8'h8F
`define MBAC_SFR_FW_LO 8'h90
`define MBAC_SFR_FW_HI 8'h97
`define MBAC_SFR_OS_LO 8'h98
`define MBAC_SFR_OS_HI 8'h9F
`define MBAC_SFR_TST_LO 8'hA0
`define MBAC_SFR_TST_HI 8'hA7
`define MBAC_SFR_CPU_LO 8'hA8
`define MBAC_SFR_CPU_HI 8'hBF
`define MBAC_SFR_HW_LO 8'hC0
`define MBAC_SFR_PROGRAM_STATUS_HIGH 8'h88
`define MBAC_SFR_HID0 8'h8D
`define MBAC_SFR_HID2 8'h8F
`define MBAC_SFR_CLOCK_SOURCE_SELECT 8'hC0
`define MBAC_SFR_RND 8'hC1
`define MBAC_SFR_KEY1 8'hC2
`define MBAC_SFR_KEY2 8'hC3

`define MBAC_RESP_OKAY 2'h0
`define MBAC_RESP_SLVERR 2'h2

`endif

// *** verilog/mbac_pkg.sv ***
/*
 Types of the mode based access checker.
 Assumes nothing beyond the constants header.
*/
package mbac_pkg;
   // CPU modes
   typedef enum logic [2:0] {
      MBAC_BOOT = 3'b000,
      MBAC_TEST = 3'b001,
      MBAC_CLOS = 3'b010,
      MBAC_SYS = 3'b011,
      MBAC_USER = 3'b100
   } mbac_mode_t;
   // Operations
   typedef enum logic [1:0] {
      MBAC_RD = 2'b00,
      MBAC_WR = 2'b01,
      MBAC_EX = 2'b10
   } mbac_op_t;
   // Target spaces
   typedef enum logic [2:0] {
      MBAC_ROM = 3'b000,
      MBAC_EE = 3'b001,
      MBAC_RAM = 3'b010,
      MBAC_CPRAM = 3'b011,
      MBAC_SFR = 3'b100
   } mbac_space_t;
endpackage

// *** verilog/mbac_checker.sv ***
/*
 Mode based access checker: allow or deny per access, setup behind AXI4-Lite.
 Assumes one access at a time on acc_*, synchronous to aclk.
*/
`include "mbac_cfg.svh"

module mbac_checker (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Access being checked
   input wire logic acc_valid,
   input wire logic acc_coproc,
   input wire logic [2:0] acc_space,
   input wire logic [1:0] acc_op,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0] sfr_rdata_in,
   output logic acc_allow,
   output logic acc_deny,
   output logic sfr_wr_en,
   output logic [7:0] sfr_rdata
);

   logic [2:0] mode_ctrl;
   logic [7:0] firewall_ctrl_low;
   logic [7:0] firewall_ctrl_high;
   logic [7:0] exchange_ram_base_low;
   logic [7:0] exchange_ram_base_high;
   logic [7:0] exchange_ram_size_low;
   logic [7:0] exchange_ram_size_high;
   logic [23:0] seg_table [`MBAC_SEG_COUNT];
   logic [5:0] code_seg;
   logic code_seg_ok;
   logic [15:0] deny_count;
   mbac_pkg::mbac_mode_t mode;
   logic wr_go;
   logic [11:0] wa;
   logic [11:0] ra;
   logic [`MBAC_SEG_COUNT-1:0] seg_hit;
   logic [5:0] hit_idx;
   logic hit_any;
   logic [23:0] hit_ent;
   logic [23:0] cur_ent;
   logic [15:0] xbase;
   logic [16:0] xend;
   logic in_xwin;
   logic rd;
   logic wr;
   logic ex;
   logic mem_ok;
   logic sfr_ok;
   logic allow;
   logic [7:0] sa;
   logic [2:0] hw_sub;

   // Mode from the status-high system bit and the two internal bits
   always_comb begin
      unique case (mode_ctrl[1:0])
         2'b01: mode = mbac_pkg::MBAC_BOOT;
         2'b10: mode = mbac_pkg::MBAC_TEST;
         2'b11: mode = mbac_pkg::MBAC_CLOS;
         default: mode = mode_ctrl[2] ? mbac_pkg::MBAC_SYS : mbac_pkg::MBAC_USER;
      endcase
   end

   // Segment match per entry; an entry with no right never matches
   genvar gi;
   generate
      for (gi = 0; gi < `MBAC_SEG_COUNT; gi++) begin : g_hit
         assign seg_hit[gi] = (|seg_table[gi][4:0])
            && (acc_addr[15:8] >= seg_table[gi][`MBAC_SEG_FIRST])
            && (acc_addr[15:8] <= seg_table[gi][`MBAC_SEG_LAST]);
      end
   endgenerate

   // Lowest matching entry wins, so overlapping entries stay deterministic
   always_comb begin
      hit_idx = 6'h00;
      hit_any = 1'b0;
      for (int i = `MBAC_SEG_COUNT - 1; i >= 0; i--) begin
         if (seg_hit[i]) begin
            hit_idx = 6'(i);
            hit_any = 1'b1;
         end
      end
   end
   assign hit_ent = seg_table[hit_idx];
   assign cur_ent = code_seg_ok ? seg_table[code_seg] : `MBAC_RST_SEG;

   // Exchange window, end kept 17 bits wide so a full-size window cannot wrap
   assign xbase = {exchange_ram_base_high, exchange_ram_base_low};
   assign xend = {1'b0, xbase} + {1'b0, exchange_ram_size_high, exchange_ram_size_low};
   assign in_xwin = (acc_addr >= xbase) && ({1'b0, acc_addr} < xend);

   assign rd = (acc_op == mbac_pkg::MBAC_RD);
   assign wr = (acc_op == mbac_pkg::MBAC_WR);
   assign ex = (acc_op == mbac_pkg::MBAC_EX);

   // Memory decision; execution from RAM is never granted
   always_comb begin
      logic trom;
      logic acm;
      logic clee;
      logic srow;
      logic clram;
      trom = (acc_addr <= `MBAC_TROM_HI);
      acm = (acc_addr >= `MBAC_ACM_LO) && (acc_addr <= `MBAC_ACM_HI);
      clee = (acc_addr <= `MBAC_CLEE_HI);
      srow = (acc_addr >= `MBAC_SECROW_LO) && (acc_addr <= `MBAC_SECROW_HI);
      clram = (acc_addr <= `MBAC_CLRAM_HI);
      mem_ok = 1'b0;
      if (acc_coproc) begin
         mem_ok = (acc_space == mbac_pkg::MBAC_EE && rd)
            || (acc_space == mbac_pkg::MBAC_CPRAM && (rd || wr));
      end else begin
         unique case (mode)
            mbac_pkg::MBAC_BOOT, mbac_pkg::MBAC_CLOS: begin
               unique case (acc_space)
                  mbac_pkg::MBAC_ROM: mem_ok = trom && (rd || ex);
                  mbac_pkg::MBAC_EE: mem_ok = clee;
                  mbac_pkg::MBAC_RAM: mem_ok = clram && !ex;
                  default: mem_ok = 1'b0;
               endcase
               if (acc_space == mbac_pkg::MBAC_EE && srow && rd) begin
                  mem_ok = 1'b1;
               end
               if (mode == mbac_pkg::MBAC_CLOS) begin
                  if (acc_space == mbac_pkg::MBAC_ROM && acm && rd) begin
                     mem_ok = 1'b1;
                  end
                  if (acc_space == mbac_pkg::MBAC_RAM && in_xwin && !ex) begin
                     mem_ok = 1'b1;
                  end
               end
            end
            mbac_pkg::MBAC_TEST: begin
               unique case (acc_space)
                  mbac_pkg::MBAC_ROM: mem_ok = rd || ex;
                  mbac_pkg::MBAC_EE: mem_ok = 1'b1;
                  mbac_pkg::MBAC_RAM: mem_ok = !ex;
                  default: mem_ok = 1'b0;
               endcase
            end
            mbac_pkg::MBAC_SYS: begin
               unique case (acc_space)
                  mbac_pkg::MBAC_ROM: mem_ok = !trom && (rd || ex);
                  mbac_pkg::MBAC_EE: mem_ok = !clee;
                  mbac_pkg::MBAC_RAM: mem_ok = !clram && !ex;
                  default: mem_ok = 1'b0;
               endcase
            end
            mbac_pkg::MBAC_USER: begin
               unique case (acc_space)
                  mbac_pkg::MBAC_ROM: mem_ok = !trom && !wr;
                  mbac_pkg::MBAC_EE: mem_ok = !clee;
                  mbac_pkg::MBAC_RAM: mem_ok = !clram && !ex;
                  default: mem_ok = 1'b0;
               endcase
               mem_ok = mem_ok && hit_any && ((rd && hit_ent[`MBAC_SEG_R])
                  || (wr && hit_ent[`MBAC_SEG_W]) || (ex && hit_ent[`MBAC_SEG_X]));
            end
            default: mem_ok = 1'b0;
         endcase
      end
   end

   assign sa = acc_addr[7:0];
   assign hw_sub = sa[5:3];

   // Special-register decision; fixed denials are applied last so nothing reopens them
   always_comb begin
      logic g_seg;
      logic g_sys;
      logic g_fw;
      logic g_os;
      logic g_cpu;
      logic g_hw;
      g_seg = (sa >= `MBAC_SFR_SEG_LO) && (sa <= `MBAC_SFR_SEG_HI);
      g_sys = (sa >= `MBAC_SFR_SYS_LO) && (sa <= `MBAC_SFR_SYS_HI);
      g_fw = (sa >= `MBAC_SFR_FW_LO) && (sa <= `MBAC_SFR_FW_HI);
      g_os = (sa >= `MBAC_SFR_OS_LO) && (sa <= `MBAC_SFR_OS_HI);
      g_cpu = (sa >= `MBAC_SFR_CPU_LO) && (sa <= `MBAC_SFR_CPU_HI);
      g_hw = (sa >= `MBAC_SFR_HW_LO);
      sfr_ok = 1'b0;
      unique case (mode)
         mbac_pkg::MBAC_BOOT, mbac_pkg::MBAC_TEST: begin
            sfr_ok = !g_seg;
         end
         mbac_pkg::MBAC_CLOS: begin
            sfr_ok = (g_fw && rd) || g_os
               || (g_hw && ((rd && firewall_ctrl_low[hw_sub]) || (wr && firewall_ctrl_high[hw_sub])));
            if (sa == `MBAC_SFR_CLOCK_SOURCE_SELECT && rd) begin
               sfr_ok = 1'b1;
            end
         end
         mbac_pkg::MBAC_SYS: begin
            sfr_ok = g_seg || g_sys || g_fw || g_hw;
         end
         mbac_pkg::MBAC_USER: begin
            sfr_ok = g_hw && ((rd && cur_ent[`MBAC_SEG_HWR]) || (wr && cur_ent[`MBAC_SEG_HWW]));
         end
         default: sfr_ok = 1'b0;
      endcase
      if (sa == `MBAC_SFR_PROGRAM_STATUS_HIGH && rd && (mode == mbac_pkg::MBAC_CLOS || mode == mbac_pkg::MBAC_USER)) begin
         sfr_ok = 1'b1;
      end
      if (g_cpu) begin
         sfr_ok = 1'b1;
      end
      if (sa >= `MBAC_SFR_HID0 && sa <= `MBAC_SFR_HID2 && rd) begin
         sfr_ok = 1'b0;
      end
      if (sa == `MBAC_SFR_RND && wr) begin
         sfr_ok = 1'b0;
      end
      if ((sa == `MBAC_SFR_KEY1 || sa == `MBAC_SFR_KEY2) && rd) begin
         sfr_ok = 1'b0;
      end
      if (ex || acc_coproc) begin
         sfr_ok = 1'b0;
      end
   end

   assign allow = acc_valid && ((acc_space == mbac_pkg::MBAC_SFR) ? sfr_ok : mem_ok);

   // Decision leaves in the cycle of the access, ahead of any update
   always_comb begin
      acc_allow = allow;
      acc_deny = acc_valid && !allow;
      sfr_wr_en = allow && wr && (acc_space == mbac_pkg::MBAC_SFR);
      sfr_rdata = (allow && rd && (acc_space == mbac_pkg::MBAC_SFR)) ? sfr_rdata_in : 8'h00;
   end

   // Current code segment, caught on each granted user fetch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_seg <= 6'h00;
         code_seg_ok <= 1'b0;
      end else if (allow && ex && !acc_coproc && mode == mbac_pkg::MBAC_USER) begin
         code_seg <= hit_idx;
         code_seg_ok <= 1'b1;
      end
   end

   // Denial counter for software; saturates rather than wrapping to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         deny_count <= 16'h0000;
      end else if (acc_valid && !allow && deny_count != 16'hFFFF) begin
         deny_count <= deny_count + 16'h0001;
      end
   end

   // Write channel: address and data are taken together, one write at a time
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         wa <= 12'h000;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go) begin
            wa <= s_axi_awaddr;
         end
      end
   end

   // Register writes and write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MBAC_RESP_OKAY;
         mode_ctrl <= `MBAC_RST_MODE;
         firewall_ctrl_low <= `MBAC_RST_BYTE;
         firewall_ctrl_high <= `MBAC_RST_BYTE;
         exchange_ram_base_low <= `MBAC_RST_BYTE;
         exchange_ram_base_high <= `MBAC_RST_BYTE;
         exchange_ram_size_low <= `MBAC_RST_BYTE;
         exchange_ram_size_high <= `MBAC_RST_BYTE;
         for (int i = 0; i < `MBAC_SEG_COUNT; i++) begin
            seg_table[i] <= `MBAC_RST_SEG;
         end
      end else if (s_axi_awready) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= `MBAC_RESP_OKAY;
         if (wa >= `MBAC_OFF_SEG && wa < `MBAC_OFF_SEG + 12'h100 && wa[1:0] == 2'b00) begin
            for (int b = 0; b < 3; b++) begin
               if (s_axi_wstrb[b]) begin
                  seg_table[wa[7:2]][b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
               end
            end
         end else if (!s_axi_wstrb[0]) begin
            s_axi_bresp <= `MBAC_RESP_OKAY;
         end else begin
            unique case (wa)
               `MBAC_OFF_MODE: mode_ctrl <= s_axi_wdata[2:0];
               `MBAC_OFF_FWLO: firewall_ctrl_low <= s_axi_wdata[7:0];
               `MBAC_OFF_FWHI: firewall_ctrl_high <= s_axi_wdata[7:0];
               `MBAC_OFF_XBLO: exchange_ram_base_low <= s_axi_wdata[7:0];
               `MBAC_OFF_XBHI: exchange_ram_base_high <= s_axi_wdata[7:0];
               `MBAC_OFF_XSLO: exchange_ram_size_low <= s_axi_wdata[7:0];
               `MBAC_OFF_XSHI: exchange_ram_size_high <= s_axi_wdata[7:0];
               `MBAC_OFF_STAT: s_axi_bresp <= `MBAC_RESP_OKAY;
               default: s_axi_bresp <= `MBAC_RESP_SLVERR;
            endcase
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one cycle of arready, data the cycle after
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         ra <= 12'h000;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            ra <= s_axi_araddr;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `MBAC_RESP_OKAY;
      end else if (s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `MBAC_RESP_OKAY;
         if (ra >= `MBAC_OFF_SEG && ra < `MBAC_OFF_SEG + 12'h100 && ra[1:0] == 2'b00) begin
            s_axi_rdata <= {8'h00, seg_table[ra[7:2]]};
         end else begin
            unique case (ra)
               `MBAC_OFF_MODE: s_axi_rdata <= {29'h00000000, mode_ctrl};
               `MBAC_OFF_FWLO: s_axi_rdata <= {24'h000000, firewall_ctrl_low};
               `MBAC_OFF_FWHI: s_axi_rdata <= {24'h000000, firewall_ctrl_high};
               `MBAC_OFF_XBLO: s_axi_rdata <= {24'h000000, exchange_ram_base_low};
               `MBAC_OFF_XBHI: s_axi_rdata <= {24'h000000, exchange_ram_base_high};
               `MBAC_OFF_XSLO: s_axi_rdata <= {24'h000000, exchange_ram_size_low};
               `MBAC_OFF_XSHI: s_axi_rdata <= {24'h000000, exchange_ram_size_high};
               `MBAC_OFF_STAT: s_axi_rdata <= {deny_count, code_seg_ok, code_seg, 6'h00, mode};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `MBAC_RESP_SLVERR;
               end
            endcase
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// *** verification/mbac_checker_properties.sv ***
/*
 Checks on the access decision port.
 Assumes a bind into mbac_checker; sees its ports only.
*/
module mbac_checker_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic acc_valid,
   input wire logic acc_coproc,
   input wire logic [2:0] acc_space,
   input wire logic [1:0] acc_op,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0] sfr_rdata_in,
   input wire logic acc_allow,
   input wire logic acc_deny,
   input wire logic sfr_wr_en,
   input wire logic [7:0] sfr_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Register access decode
   wire logic sfr_acc = acc_valid && acc_space == 3'h4;
   wire logic sfr_rd = sfr_acc && acc_op == 2'h0;
   wire logic [7:0] ra = acc_addr[7:0];
   AST_ONE_DECISION: assert property (acc_valid |-> acc_allow ^ acc_deny)
      else $error("allow and deny clash");
   AST_IDLE_QUIET: assert property (!acc_valid |-> !(acc_allow || acc_deny || sfr_wr_en) && sfr_rdata == 8'h00)
      else $error("outputs active when idle");
   AST_DENIED_READ_ZERO: assert property (sfr_rd && acc_deny |-> sfr_rdata == 8'h00)
      else $error("refused read leaks data");
   AST_ALLOWED_READ_PASS: assert property (sfr_rd && acc_allow |-> sfr_rdata == sfr_rdata_in)
      else $error("allowed read data wrong");
   AST_WRITE_GATE: assert property (sfr_wr_en == (sfr_acc && acc_op == 2'h1 && acc_allow))
      else $error("write enable wrong");
   AST_HIDDEN_READ: assert property (sfr_rd && ra >= 8'h8D && ra <= 8'h8F |-> sfr_rdata == 8'h00)
      else $error("hidden reg read");
   AST_KEY_READ: assert property (sfr_rd && (ra == 8'hC2 || ra == 8'hC3) |-> sfr_rdata == 8'h00)
      else $error("key reg read");
   AST_RANDOM_RO: assert property (sfr_acc && ra == 8'hC1 |-> !sfr_wr_en)
      else $error("random reg written");
   AST_CPU_REGS: assert property (sfr_acc && !acc_coproc && acc_op != 2'h2 && ra >= 8'hA8 && ra <= 8'hBF |-> acc_allow)
      else $error("cpu reg refused");
   AST_COPROC: assert property (acc_valid && acc_coproc && (acc_space == 3'h3 && !acc_op[1] ||
      acc_space == 3'h1 && acc_op == 2'h0) |-> acc_allow)
      else $error("coproc refused");
endmodule

bind mbac_checker mbac_checker_props props_i (.aclk, .aresetn, .acc_valid, .acc_coproc, .acc_space, .acc_op,
   .acc_addr, .sfr_rdata_in, .acc_allow, .acc_deny, .sfr_wr_en, .sfr_rdata);

// *** verification/mbac_cpu_model.sv ***
/*
 CPU and coprocessor model, with the register file behind the checker.
 Assumes a same-cycle decision and writes gated by sfr_wr_en.
*/
module mbac_cpu_model (
   input wire logic aclk,
   input wire logic sfr_wr_en,
   output logic acc_valid,
   output logic acc_coproc,
   output logic [2:0] acc_space,
   output logic [1:0] acc_op,
   output logic [15:0] acc_addr,
   output logic [7:0] sfr_rdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sfr [256];
   // Preset nonzero except at 0x5A: a leak differs from a refusal
   initial begin
      acc_valid = 1'b0;
      acc_coproc = 1'b0;
      acc_space = 3'h0;
      acc_op = 2'h0;
      acc_addr = 16'h0000;
      for (int i = 0; i < 256; i++) sfr[i] = 8'(i) ^ 8'h5A;
   end
   assign sfr_rdata_in = sfr[acc_addr[7:0]];
   // A granted write inverts the cell
   always @(posedge aclk) begin
      if (sfr_wr_en) sfr[acc_addr[7:0]] <= ~sfr[acc_addr[7:0]];
   end
   task automatic issue(input logic c, input logic [2:0] s, input logic [1:0] o, input logic [15:0] a);
      @(posedge aclk);
      acc_valid <= 1'b1;
      acc_coproc <= c;
      acc_space <= s;
      acc_op <= o;
      acc_addr <= a;
   endtask
   // Release inverts the address so nothing stale looks live
   task automatic release_port();
      @(posedge aclk);
      acc_valid <= 1'b0;
      acc_addr <= ~acc_addr;
   endtask
endmodule

// *** verification/tb_mode_based_access_checker.sv ***
/*
 Bench: setup over AXI4-Lite, accesses via the CPU model.
 Assumes a same-cycle decision.
*/
module tb_mode_based_access_checker;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, acc_valid, acc_coproc, acc_allow, acc_deny, sfr_wr_en, cop = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, acc_op;
   logic [2:0] acc_space;
   logic [15:0] acc_addr;
   logic [7:0] sfr_rdata_in, sfr_rdata;
   int n_mismatch = 0, n_tests = 0, n_deny = 0;
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   mbac_checker DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid, .acc_coproc,
      .acc_space, .acc_op, .acc_addr, .sfr_rdata_in, .acc_allow, .acc_deny, .sfr_wr_en, .sfr_rdata);
   mbac_cpu_model cpu (.aclk, .sfr_wr_en, .acc_valid, .acc_coproc, .acc_space, .acc_op, .acc_addr, .sfr_rdata_in);
   task automatic wrap_up();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Address and data together, each dropped on its ready
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp({30'h0, s_axi_bresp}, {30'h0, r});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata & m, e);
      cmp({30'h0, s_axi_rresp}, {30'h0, r});
   endtask
   // One-cycle access; data only for a granted register read
   task automatic chk(input logic [2:0] s, input logic [1:0] o, input logic [15:0] a, input logic ok);
      logic [7:0] ev;
      cpu.issue(cop, s, o, a);
      #1;
      ev = (ok && s == 3'h4 && o == 2'h0) ? cpu.sfr[a[7:0]] : 8'h00;
      cmp({21'h0, acc_allow, acc_deny, sfr_wr_en, sfr_rdata}, {21'h0, ok, !ok, ok && s == 3'h4 && o == 2'h1, ev});
      n_deny += !ok;
      cpu.release_port();
   endtask
   // Watchdog, well beyond the run length
   initial begin
      #20000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h01C, 32'h4, 32'hFFFF, 2'h0);
      rd(12'h020, 32'h0, 32'hFFFFFFFF, 2'h2);
      wr(12'h020, 32'h1, 2'h2);
      // User mode, starting from an empty segment table
      chk(3'h0, 2'h2, 16'h2000, 1'b0);
      chk(3'h4, 2'h1, 16'h00BF, 1'b1);
      chk(3'h4, 2'h0, 16'h0088, 1'b1);
      chk(3'h4, 2'h1, 16'h0088, 1'b0);
      chk(3'h4, 2'h0, 16'h0080, 1'b0);
      chk(3'h4, 2'h0, 16'h00C8, 1'b0);
      wr(12'h100, 32'h002F200D, 2'h0);
      wr(12'h104, 32'h003F3000, 2'h0);
      wr(12'h1FC, 32'h00404002, 2'h0);
      chk(3'h0, 2'h2, 16'h2000, 1'b1);
      chk(3'h0, 2'h0, 16'h2FFF, 1'b1);
      chk(3'h0, 2'h0, 16'h3000, 1'b0);
      chk(3'h1, 2'h1, 16'h2000, 1'b0);
      chk(3'h1, 2'h1, 16'h40FF, 1'b1);
      chk(3'h2, 2'h0, 16'h4000, 1'b0);
      chk(3'h4, 2'h0, 16'h00C8, 1'b1);
      chk(3'h4, 2'h1, 16'h00C8, 1'b0);
      rd(12'h01C, 32'h8004, 32'hFFFF, 2'h0);
      // Boot mode
      wr(12'h000, 32'h1, 2'h0);
      chk(3'h0, 2'h2, 16'h0FFF, 1'b1);
      chk(3'h0, 2'h0, 16'h1000, 1'b0);
      chk(3'h1, 2'h1, 16'h0FFF, 1'b1);
      chk(3'h1, 2'h0, 16'h107F, 1'b1);
      chk(3'h1, 2'h1, 16'h1000, 1'b0);
      chk(3'h2, 2'h1, 16'h00FF, 1'b1);
      chk(3'h2, 2'h0, 16'h0100, 1'b0);
      chk(3'h2, 2'h2, 16'h0000, 1'b0);
      chk(3'h4, 2'h1, 16'h00C1, 1'b0);
      chk(3'h4, 2'h0, 16'h008D, 1'b0);
      chk(3'h4, 2'h0, 16'h008F, 1'b0);
      chk(3'h4, 2'h0, 16'h00C2, 1'b0);
      chk(3'h4, 2'h0, 16'h00C3, 1'b0);
      chk(3'h4, 2'h1, 16'h009F, 1'b1);
      chk(3'h4, 2'h0, 16'h00A0, 1'b1);
      chk(3'h4, 2'h1, 16'h0087, 1'b0);
      // Test mode
      wr(12'h000, 32'h2, 2'h0);
      chk(3'h0, 2'h2, 16'hFFFF, 1'b1);
      chk(3'h0, 2'h1, 16'h0000, 1'b0);
      chk(3'h1, 2'h1, 16'h1000, 1'b1);
      chk(3'h2, 2'h1, 16'hFFFF, 1'b1);
      chk(3'h4, 2'h1, 16'h00FF, 1'b1);
      // Contactless OS mode, exchange window 0x0400..0x040F
      wr(12'h010, 32'h4, 2'h0);
      wr(12'h014, 32'h10, 2'h0);
      wr(12'h000, 32'h3, 2'h0);
      chk(3'h0, 2'h2, 16'h0FFF, 1'b1);
      chk(3'h1, 2'h1, 16'h0000, 1'b1);
      chk(3'h0, 2'h0, 16'h103F, 1'b1);
      chk(3'h0, 2'h0, 16'h1040, 1'b0);
      chk(3'h1, 2'h0, 16'h1000, 1'b1);
      chk(3'h2, 2'h1, 16'h040F, 1'b1);
      chk(3'h2, 2'h0, 16'h0410, 1'b0);
      chk(3'h2, 2'h0, 16'h03FF, 1'b0);
      chk(3'h4, 2'h0, 16'h0090, 1'b1);
      chk(3'h4, 2'h1, 16'h0090, 1'b0);
      chk(3'h4, 2'h1, 16'h0098, 1'b1);
      chk(3'h4, 2'h0, 16'h0098, 1'b1);
      chk(3'h4, 2'h0, 16'h0088, 1'b1);
      chk(3'h4, 2'h0, 16'h00C0, 1'b1);
      chk(3'h4, 2'h0, 16'h00C8, 1'b0);
      wr(12'h004, 32'h2, 2'h0);
      chk(3'h4, 2'h0, 16'h00C8, 1'b1);
      chk(3'h4, 2'h1, 16'h00CF, 1'b0);
      wr(12'h008, 32'h2, 2'h0);
      chk(3'h4, 2'h1, 16'h00CF, 1'b1);
      // System mode
      wr(12'h000, 32'h4, 2'h0);
      chk(3'h0, 2'h2, 16'h2000, 1'b1);
      chk(3'h0, 2'h0, 16'h0000, 1'b0);
      chk(3'h1, 2'h1, 16'h0000, 1'b0);
      chk(3'h2, 2'h1, 16'h0100, 1'b1);
      chk(3'h4, 2'h1, 16'h0080, 1'b1);
      chk(3'h4, 2'h1, 16'h0097, 1'b1);
      chk(3'h4, 2'h1, 16'h00FF, 1'b1);
      // Coprocessor
      cop = 1'b1;
      chk(3'h1, 2'h0, 16'h0000, 1'b1);
      chk(3'h3, 2'h1, 16'h0010, 1'b1);
      cop = 1'b0;
      chk(3'h3, 2'h0, 16'h0010, 1'b0);
      rd(12'h01C, {n_deny[15:0], 16'h0}, 32'hFFFF0000, 2'h0);
      // Second reset: user mode, table cleared
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h01C, 32'h4, 32'hFFFFFFFF, 2'h0);
      chk(3'h0, 2'h2, 16'h2000, 1'b0);
      wrap_up();
   end
endmodule
